// ---- rtl/nvm_ctrl_cfg.svh ----
// offsets, field positions, reset values and codes of the nvm control block
`ifndef NVM_CTRL_CFG_SVH
`define NVM_CTRL_CFG_SVH

`define NVM_ADDR_W 4
`define NVM_OFS_CTRL 4'h0
`define NVM_OFS_IRQ_STATUS 4'h4
`define NVM_OFS_IRQ_MASK 4'h8

`define NVM_BIT_READ_START 0
`define NVM_BIT_WRITE_START 1
`define NVM_BIT_WRITE_PERMIT 2
`define NVM_BIT_WRITE_ERROR 3
`define NVM_BIT_ROW_ERASE 4
`define NVM_BIT_PROG_SELECT 7

`define NVM_EVT_W 3
`define NVM_EVT_WRITE_DONE 0
`define NVM_EVT_WRITE_ERROR 1
`define NVM_EVT_READ_DONE 2

`define NVM_CTRL_RESET 8'h00
`define NVM_IRQ_RESET 3'h0

`define NVM_RESP_OKAY 2'b00
`define NVM_RESP_DECERR 2'b11

`endif

// ---- rtl/nvm_ctrl_pkg.sv ----
// types shared by the nvm control block
package nvm_ctrl_pkg;

  typedef struct packed {
    logic write_go;
    logic read_go;
    logic abort;
    logic busy;
    logic erase;
    logic prog_select;
  } engine_cmd_type;

  typedef struct packed {
    logic write_done;
    logic master_clear_reset;
    logic watchdog_timer;
  } engine_stat_type;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_BUSY = 2'b01
  } wr_state_type;

endpackage : nvm_ctrl_pkg

// ---- rtl/nvm_event_flags.sv ----
// sticky event status with mask and one level interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_cfg.svh"

module nvm_event_flags (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`NVM_EVT_W-1:0] events,
  input wire logic clear_en,
  input wire logic [`NVM_EVT_W-1:0] clear_bits,
  input wire logic mask_en,
  input wire logic [`NVM_EVT_W-1:0] mask_bits,
  output logic [`NVM_EVT_W-1:0] status_r,
  output logic [`NVM_EVT_W-1:0] mask_r,
  output logic irq_r
);

  logic [`NVM_EVT_W-1:0] status_nxt;

  // a new event wins over a write-one-to-clear in the same cycle
  always_comb begin
    status_nxt = status_r;
    if (clear_en) begin
      status_nxt = status_nxt & ~clear_bits;
    end
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      status_r <= `NVM_IRQ_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_r <= `NVM_IRQ_RESET;
    end else if (mask_en) begin
      mask_r <= mask_bits;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & (mask_en ? mask_bits : mask_r));
    end
  end

endmodule : nvm_event_flags
`default_nettype wire

// ---- rtl/nvm_rw_control_bits.sv ----
// control and status bits for nonvolatile reads and self-timed writes
//
// Notes on behaviour
// - error flag stays 0 after a write that completed normally
// - flagged error leaves memory select and row erase unchanged
// - erase or write cycles only while write permit is 1
// - setting write start launches an eeprom or program memory cycle
// - cycle is self-timed; hardware clears write start when done
// - software can only set write start, writing 0 does nothing
// - read start launches a one-cycle read, then hardware clears it
// - read start cannot be set while program memory is selected
// - master clear or watchdog reset during a write sets the error flag
// - row erase set erases the addressed row, cleared when erase completes
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_cfg.svh"

module nvm_rw_control_bits (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`NVM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`NVM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire nvm_ctrl_pkg::engine_stat_type eng_stat,
  output nvm_ctrl_pkg::engine_cmd_type eng_cmd,
  output logic irq
);
  import nvm_ctrl_pkg::*;

  // bus write side
  logic aw_held_r;
  logic w_held_r;
  logic [`NVM_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // bus read side
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // control bits
  wr_state_type wr_state_r;
  logic read_start_r;
  logic write_permit_r;
  logic write_error_flag_r;
  logic row_erase_enable_r;
  logic program_memory_select_r;
  engine_cmd_type cmd_r;

  logic [`NVM_EVT_W-1:0] status;
  logic [`NVM_EVT_W-1:0] mask;
  logic irq_r;

  logic do_write;
  logic ctrl_wr;
  logic abort_evt;
  logic write_go;
  logic read_go;
  logic write_done;
  logic write_busy;
  logic [7:0] wbyte;
  logic [`NVM_EVT_W-1:0] events;

  function automatic logic mapped(input logic [`NVM_ADDR_W-1:0] a);
    mapped = (a == `NVM_OFS_CTRL) || (a == `NVM_OFS_IRQ_STATUS) ||
             (a == `NVM_OFS_IRQ_MASK);
  endfunction : mapped

  function automatic logic hit(input logic [`NVM_ADDR_W-1:0] a,
                               input logic [`NVM_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // reset value of one control bit, picked out of the packed reset word
  function automatic logic ctrl_reset_bit(input int pos);
    logic [7:0] word;
    word = `NVM_CTRL_RESET;
    ctrl_reset_bit = word[pos];
  endfunction : ctrl_reset_bit

  // control word as software reads it; bits without a meaning read 0
  function automatic logic [31:0] ctrl_word(input logic prog_sel,
                                            input logic row_erase,
                                            input logic wr_err,
                                            input logic permit,
                                            input logic wr_busy,
                                            input logic rd_start);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`NVM_BIT_PROG_SELECT] = prog_sel;
    w[`NVM_BIT_ROW_ERASE] = row_erase;
    w[`NVM_BIT_WRITE_ERROR] = wr_err;
    w[`NVM_BIT_WRITE_PERMIT] = permit;
    w[`NVM_BIT_WRITE_START] = wr_busy;
    w[`NVM_BIT_READ_START] = rd_start;
    ctrl_word = w;
  endfunction : ctrl_word

  // address and data are taken in either order, response after both
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wbyte = wdata_r[7:0];
  assign ctrl_wr = do_write && hit(awaddr_r, `NVM_OFS_CTRL) && wstrb_r[0];
  assign write_busy = (wr_state_r == WR_BUSY);
  assign abort_evt = write_busy &&
                     (eng_stat.master_clear_reset || eng_stat.watchdog_timer);
  assign write_done = write_busy && eng_stat.write_done && !abort_evt;

  assign write_go = ctrl_wr && wbyte[`NVM_BIT_WRITE_START] &&
                    write_permit_r && (wr_state_r == WR_IDLE);

  assign read_go = ctrl_wr && wbyte[`NVM_BIT_READ_START] &&
                   !program_memory_select_r && !read_start_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // ready flops drop the cycle an item is taken, so no second item slips in
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) &&
                       !bvalid_r && !do_write;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) &&
                      !bvalid_r && !do_write;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // unmapped offsets answer with a decode error and change nothing
  always_ff @(posedge mclk) begin
    if (reset) begin
      bresp_r <= `NVM_RESP_OKAY;
    end else if (do_write) begin
      bresp_r <= mapped(awaddr_r) ? `NVM_RESP_OKAY : `NVM_RESP_DECERR;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !rvalid_r && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `NVM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= mapped(s_axi_araddr) ? `NVM_RESP_OKAY : `NVM_RESP_DECERR;
      rdata_r <= 32'h0000_0000;
      if (hit(s_axi_araddr, `NVM_OFS_CTRL)) begin
        rdata_r <= ctrl_word(program_memory_select_r, row_erase_enable_r,
                             write_error_flag_r, write_permit_r,
                             write_busy, read_start_r);
      end else if (hit(s_axi_araddr, `NVM_OFS_IRQ_STATUS)) begin
        rdata_r[`NVM_EVT_W-1:0] <= status;
      end else if (hit(s_axi_araddr, `NVM_OFS_IRQ_MASK)) begin
        rdata_r[`NVM_EVT_W-1:0] <= mask;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // write cycle tracking; the state is the write start bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_state_r <= WR_IDLE;
    end else begin
      case (wr_state_r)
        WR_IDLE: begin
          if (write_go) begin
            wr_state_r <= WR_BUSY;
          end
        end
        WR_BUSY: begin
          if (write_done || abort_evt) begin
            wr_state_r <= WR_IDLE;
          end
        end
        default: begin
          wr_state_r <= WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      read_start_r <= ctrl_reset_bit(`NVM_BIT_READ_START);
    end else begin
      read_start_r <= read_go;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      write_permit_r <= ctrl_reset_bit(`NVM_BIT_WRITE_PERMIT);
    end else if (ctrl_wr) begin
      write_permit_r <= wbyte[`NVM_BIT_WRITE_PERMIT];
    end
  end

  // selection is frozen while a cycle runs so the engine sees stable inputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      program_memory_select_r <= ctrl_reset_bit(`NVM_BIT_PROG_SELECT);
    end else if (ctrl_wr && wr_state_r == WR_IDLE) begin
      program_memory_select_r <= wbyte[`NVM_BIT_PROG_SELECT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      row_erase_enable_r <= ctrl_reset_bit(`NVM_BIT_ROW_ERASE);
    end else if (write_done && row_erase_enable_r) begin
      row_erase_enable_r <= 1'b0;
    end else if (ctrl_wr && wr_state_r == WR_IDLE) begin
      row_erase_enable_r <= wbyte[`NVM_BIT_ROW_ERASE];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      write_error_flag_r <= ctrl_reset_bit(`NVM_BIT_WRITE_ERROR);
    end else if (abort_evt) begin
      write_error_flag_r <= 1'b1;
    end else if (write_done) begin
      write_error_flag_r <= 1'b0;
    end else if (ctrl_wr) begin
      write_error_flag_r <= wbyte[`NVM_BIT_WRITE_ERROR];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_r <= '0;
    end else begin
      cmd_r.write_go <= write_go;
      cmd_r.read_go <= read_go;
      cmd_r.abort <= abort_evt;
      cmd_r.busy <= write_busy ? !(write_done || abort_evt) : write_go;
      cmd_r.erase <= row_erase_enable_r;
      cmd_r.prog_select <= program_memory_select_r;
    end
  end

  always_comb begin
    events = '0;
    events[`NVM_EVT_WRITE_DONE] = write_done;
    events[`NVM_EVT_WRITE_ERROR] = abort_evt;
    events[`NVM_EVT_READ_DONE] = read_start_r;
  end

  nvm_event_flags u_flags (
    .mclk(mclk),
    .reset(reset),
    .events(events),
    .clear_en(do_write && hit(awaddr_r, `NVM_OFS_IRQ_STATUS) && wstrb_r[0]),
    .clear_bits(wdata_r[`NVM_EVT_W-1:0]),
    .mask_en(do_write && hit(awaddr_r, `NVM_OFS_IRQ_MASK) && wstrb_r[0]),
    .mask_bits(wdata_r[`NVM_EVT_W-1:0]),
    .status_r(status),
    .mask_r(mask),
    .irq_r(irq_r)
  );

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign eng_cmd = cmd_r;
  assign irq = irq_r;

endmodule : nvm_rw_control_bits
`default_nettype wire

// ---- dv/nvm_rw_control_bits_props.sv ----
// assertions on the ports of the nvm control bit block
`timescale 1ns/1ps
`default_nettype none
module nvm_rw_props (
  input wire logic mclk,
  input wire logic reset,
  input wire nvm_ctrl_pkg::engine_stat_type eng_stat,
  input wire nvm_ctrl_pkg::engine_cmd_type eng_cmd,
  input wire logic irq
);
  import nvm_ctrl_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic hit;
  // either reset source cuts a running cycle short
  assign hit = eng_stat.master_clear_reset | eng_stat.watchdog_timer;
  a_go_with_busy: assert property (eng_cmd.write_go |-> eng_cmd.busy)
    else $error("write start pulse without busy");
  a_go_one_pulse: assert property (eng_cmd.write_go |=> !eng_cmd.write_go)
    else $error("write start pulse too long");
  a_busy_from_go: assert property ($rose(eng_cmd.busy) |-> eng_cmd.write_go)
    else $error("busy rose without a start pulse");
  a_done_ends_busy: assert property
    (eng_cmd.busy && eng_stat.write_done |=> !eng_cmd.busy)
    else $error("busy kept after completion");
  a_busy_holds: assert property
    (eng_cmd.busy && !eng_stat.write_done && !hit |=> eng_cmd.busy)
    else $error("busy dropped early");
  a_abort_flags: assert property
    (eng_cmd.busy && hit |-> ##[0:1] eng_cmd.abort)
    else $error("no abort after reset in a cycle");
  a_abort_keeps: assert property ($past(eng_cmd.busy) && eng_cmd.busy && hit
    |=> $stable(eng_cmd.erase) && $stable(eng_cmd.prog_select))
    else $error("select or erase changed on abort");
  a_erase_done: assert property
    (eng_cmd.busy && eng_stat.write_done && !hit |=> ##1 !eng_cmd.erase)
    else $error("row erase kept after completion");
  a_read_pulse: assert property
    (eng_cmd.read_go |-> !eng_cmd.prog_select ##1 !eng_cmd.read_go)
    else $error("bad read pulse");
  cover property (eng_cmd.abort);
  cover property (eng_cmd.read_go);
  cover property (eng_cmd.busy && eng_stat.write_done);
  cover property (irq);
endmodule : nvm_rw_props

bind nvm_rw_control_bits nvm_rw_props props (.mclk(mclk), .reset(reset),
  .eng_stat(eng_stat), .eng_cmd(eng_cmd), .irq(irq));
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the nvm control bit block
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_cfg.svh"
module testbench;
  import nvm_ctrl_pkg::*;
  logic mclk = 1'h0;
  logic reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [`NVM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  engine_stat_type eng_stat;
  engine_cmd_type eng_cmd;
  int errors = 0, comparisons = 0, wgo = 0, rgo = 0, seed;
  logic [31:0] rnd;
  nvm_rw_control_bits dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eng_stat, .eng_cmd, .irq);
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (eng_cmd.write_go === 1'h1) wgo++;
    if (eng_cmd.read_go === 1'h1) rgo++;
  end
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // only the event bits of the mask exist; the rest reads 0
  function automatic logic [31:0] mask_exp(input logic [31:0] d);
    mask_exp = d & 32'h0000_0007;
  endfunction : mask_exp
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    // one edge between transfers, so no strobe is driven twice at once
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    // upper strobes are don't-care, so they are thrown at random
    s_axi_wstrb <= {3'($random(seed)), 1'h1};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    if (!s_axi_bvalid) begin
      errors++;
      $display("Error at %0t: no write response", $time);
    end
    chk(32'(s_axi_bresp), 32'(r));
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    if (!s_axi_rvalid) begin
      errors++;
      $display("Error at %0t: no read response", $time);
    end
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask : rd
  // engine event after a random delay of one to eight cycles
  task automatic ev(input logic [2:0] s);
    repeat (1 + $unsigned($random(seed)) % 8) @(posedge mclk);
    eng_stat <= engine_stat_type'(s);
    @(posedge mclk);
    eng_stat <= '0;
  endtask : ev
  initial begin
    #100000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    seed = 47226;
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wstrb, s_axi_wdata} = '0;
    eng_stat = '0;
    repeat (8) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    rd(4'h0, 32'h0, 2'h0);
    rd(4'h4, 32'h0, 2'h0);
    rd(4'h8, 32'h0, 2'h0);
    rd(4'hc, 32'h0, 2'h3);
    $display("test reset done");
    wr(4'h0, 32'h02, 2'h0);
    rd(4'h0, 32'h0, 2'h0);
    chk(wgo, 0);
    // permit must already stand when the start bit is written
    wr(4'h0, 32'h04, 2'h0);
    wr(4'h0, 32'h06, 2'h0);
    chk(eng_cmd.busy, 1);
    wr(4'h0, 32'h04, 2'h0);
    rd(4'h0, 32'h06, 2'h0);
    ev(3'h4);
    rd(4'h0, 32'h04, 2'h0);
    for (int k = 0; k < 3; k++) begin
      wr(4'h0, 32'h96, 2'h0);
      ev(k == 0 ? 3'h4 : (k == 1 ? 3'h2 : 3'h1));
      rd(4'h0, k == 0 ? 32'h84 : 32'h9c, 2'h0);
    end
    wr(4'h0, 32'h8e, 2'h0);
    ev(3'h4);
    rd(4'h0, 32'h84, 2'h0);
    chk(wgo, 5);
    $display("test write cycles done");
    wr(4'h0, 32'h81, 2'h0);
    rd(4'h0, 32'h80, 2'h0);
    chk(rgo, 0);
    wr(4'h0, 32'h00, 2'h0);
    wr(4'h0, 32'h01, 2'h0);
    rd(4'h0, 32'h00, 2'h0);
    chk(rgo, 1);
    $display("test read done");
    rd(4'h4, 32'h7, 2'h0);
    chk(irq, 0);
    wr(4'h8, 32'h2, 2'h0);
    chk(irq, 1);
    wr(4'h4, 32'h2, 2'h0);
    rd(4'h4, 32'h5, 2'h0);
    chk(irq, 0);
    wr(4'hc, 32'hff, 2'h3);
    rd(4'h8, 32'h2, 2'h0);
    // status holds bits 0 and 2 here, so the level follows the random mask
    for (int k = 0; k < 4; k++) begin
      rnd = $random(seed);
      wr(4'h8, rnd, 2'h0);
      rd(4'h8, mask_exp(rnd), 2'h0);
      chk(irq, {31'h0, |(rnd[2:0] & 3'h5)});
    end
    $display("test interrupt done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
